//--- pkg/dtg_pkg.sv
package dtg_pkg;

   // ---------------------------------------------------------------
   // clocks and timing
   // ---------------------------------------------------------------
   localparam int          CLK_HZ       = 25_000_000;
   localparam int          CRYS_HZ      = 3_579_545;
   localparam int          ACC_W        = 24;
   // crystal rate as a phase increment of the system clock
   localparam logic [24:0] CRYS_INC     =
      25'((64'(CRYS_HZ) << ACC_W) / 64'(CLK_HZ));
   localparam int          SEG_COUNT    = 32;
   localparam int          SEG_W        = $clog2(SEG_COUNT);
   localparam int          BURST_US     = 51_000;
   localparam int          BURST_CYCLES =
      int'((64'(BURST_US) * 64'(CLK_HZ)) / 64'd1_000_000);
   localparam int          GTP_CYCLES   = 1000;
   localparam int          GTA_CYCLES   = 1000;

   // ---------------------------------------------------------------
   // register addresses and fields
   // ---------------------------------------------------------------
   localparam logic ADDR_DATA   = 1'b0;
   localparam logic ADDR_CTRL   = 1'b1;
   localparam int   CTLA_TONE   = 0;
   localparam int   CTLA_CPSEL  = 1;
   localparam int   CTLA_IRQ    = 2;
   localparam int   CTLA_BSEL   = 3;
   localparam int   CTLB_BURST  = 0;
   localparam int   CTLB_TEST   = 1;
   localparam int   CTLB_SINGLE = 2;
   localparam int   CTLB_COLUMN = 3;
   localparam int   ST_IRQ      = 0;
   localparam int   ST_TXRDY    = 1;
   localparam int   ST_RXVALID  = 2;
   localparam int   ST_DSTEER_N = 3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] CTLA_RST  = 4'h0;
   localparam logic [3:0] CTLB_RST  = 4'h0;
   localparam logic [3:0] CODE_RST  = 4'h0;
   localparam logic       TXRDY_RST = 1'b1;

   // ---------------------------------------------------------------
   // divider lengths in crystal ticks per segment
   // ---------------------------------------------------------------
   localparam logic [7:0] DIV_L1 = 8'ha0;
   localparam logic [7:0] DIV_L2 = 8'h92;
   localparam logic [7:0] DIV_L3 = 8'h84;
   localparam logic [7:0] DIV_L4 = 8'h76;
   localparam logic [7:0] DIV_H1 = 8'h5c;
   localparam logic [7:0] DIV_H2 = 8'h54;
   localparam logic [7:0] DIV_H3 = 8'h4c;
   localparam logic [7:0] DIV_H4 = 8'h44;

   typedef enum logic [1:0] {
      BURST_IDLE,
      BURST_ON,
      BURST_PAUSE
   } dtg_burst_type;

endpackage

//--- verilog/dtg_top.sv
// Overview of operation
// [RL1] each tone period is 32 equal segments; frequency set by segment length
// [RL2] transmit write latches 4-bit code, converts to two-of-eight selection
// [RL3] divider counts to code-chosen terminal, pulses, restarts; pulse is segment
// [RL4] divider steps a sine table counter; separate row and column paths
// [RL5] all tone timing divided from the 3.579545 MHz crystal rate; burst, pause and guard times are counted in system clock cycles
// [RL6] transmit code equals receive code; standard low and high tones
// [RL7] divider lengths give the listed actual frequencies
// [RL8] burst mode, DTMF: 51 ms tone then 51 ms pause
// [RL9] after burst and pause, flag transmitter ready for next code
// [RL10] call progress mode doubles burst and pause to 102 ms
// [RL11] call progress with burst: transmit only, no tone pair decoding
// [RL12] host times odd bursts itself by toggling tone output, burst off
// [RL13] single tone mode makes only one low or one high tone
// [RL14] oscillator runs always; tone starts at once when enabled
// [RL15] tone pair shorter than recognition time leaves receive data alone
// [RL16] short dropouts keep code; code held after valid end until next
// [RL17] status bit 3 shows delayed steering, low while signal valid
// [RL18] status bit 2 set on new receive data, cleared by status read
// [RL19] interrupt active on new receive data, released by status read
// [RL20] tone output enable gates all transmit tone output
// [RL21] mode bit: set selects call progress, clear DTMF; no pair detection
// [RL22] each path presents its sine table code at every counter step
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dtg_top #(
   parameter int BURST_CYCLES = dtg_pkg::BURST_CYCLES,
   parameter int GTP_CYCLES   = dtg_pkg::GTP_CYCLES,
   parameter int GTA_CYCLES   = dtg_pkg::GTA_CYCLES
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // register port
   input  wire logic       addr_i,
   input  wire logic [3:0] wr_data_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [3:0] rd_data_o,
   // receiver detector
   input  wire logic       early_steering_i,
   input  wire logic [3:0] rx_digit_code_i,
   output logic            steering_guard_o,
   // interrupt pin, open drain
   output logic            interrupt_or_tone_pin_o,
   output logic            interrupt_or_tone_pin_oe_o,
   // tone samples
   output logic      [7:0] row_sample_o,
   output logic      [7:0] col_sample_o,
   output logic            tone_active_o
);

   // ---------------------------------------------------------------
   // limits
   // ---------------------------------------------------------------
   localparam int          SW        = dtg_pkg::SEG_W;
   localparam logic [21:0] BURST_LEN = 22'(BURST_CYCLES);
   localparam logic [19:0] GTP_LAST  = 20'(GTP_CYCLES - 1);
   localparam logic [19:0] GTA_LAST  = 20'(GTA_CYCLES - 1);

   typedef struct packed {
      logic [23:0]            acc;
      logic                   tick;
      logic [7:0]             row_div;
      logic [7:0]             col_div;
      logic [SW-1:0]          row_step;
      logic [SW-1:0]          col_step;
      logic [7:0]             tx_sel;
      logic [3:0]             rx_code;
      logic [3:0]             ctla;
      logic [3:0]             ctlb;
      logic                   ctlb_pend;
      dtg_pkg::dtg_burst_type phase;
      logic [21:0]            bcnt;
      logic                   tx_ready;
      logic                   es_s1;
      logic                   es_s2;
      logic                   es_s3;
      logic                   es_lvl;
      logic [3:0]             code_s1;
      logic [3:0]             code_s2;
      logic [3:0]             code_s3;
      logic [3:0]             code_lvl;
      logic [19:0]            gcnt;
      logic                   dsteer;
      logic                   rx_valid;
      logic                   irq;
      logic [3:0]             rdata;
      logic [7:0]             row_smp;
      logic [7:0]             col_smp;
      logic                   active;
   } dtg_state_type;

   dtg_state_type state_reg;
   dtg_state_type state_next;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // low nibble selects the row tone, high nibble the column tone
   function automatic logic [7:0] two_of_eight(input logic [3:0] code);
      logic [3:0] row;
      logic [3:0] col;
      row = 4'h0;
      col = 4'h0;
      unique case (code)
         4'h1: begin row = 4'h1; col = 4'h1; end
         4'h2: begin row = 4'h1; col = 4'h2; end
         4'h3: begin row = 4'h1; col = 4'h4; end
         4'h4: begin row = 4'h2; col = 4'h1; end
         4'h5: begin row = 4'h2; col = 4'h2; end
         4'h6: begin row = 4'h2; col = 4'h4; end
         4'h7: begin row = 4'h4; col = 4'h1; end
         4'h8: begin row = 4'h4; col = 4'h2; end
         4'h9: begin row = 4'h4; col = 4'h4; end
         4'ha: begin row = 4'h8; col = 4'h2; end
         4'hb: begin row = 4'h8; col = 4'h1; end
         4'hc: begin row = 4'h8; col = 4'h4; end
         4'hd: begin row = 4'h1; col = 4'h8; end
         4'he: begin row = 4'h2; col = 4'h8; end
         4'hf: begin row = 4'h4; col = 4'h8; end
         4'h0: begin row = 4'h8; col = 4'h8; end
      endcase
      return {col, row};
   endfunction

   function automatic logic [7:0] seg_len(input logic [3:0] sel,
                                          input logic       high);
      logic [7:0] len;
      len = high ? dtg_pkg::DIV_H1 : dtg_pkg::DIV_L1;
      if (sel[1]) begin
         len = high ? dtg_pkg::DIV_H2 : dtg_pkg::DIV_L2;
      end
      if (sel[2]) begin
         len = high ? dtg_pkg::DIV_H3 : dtg_pkg::DIV_L3;
      end
      if (sel[3]) begin
         len = high ? dtg_pkg::DIV_H4 : dtg_pkg::DIV_L4;
      end
      return len;
   endfunction

   // returns {divider, step}; >= keeps a shortened length from overrunning
   function automatic logic [8+SW-1:0] advance(input logic [7:0]    cnt,
                                               input logic [SW-1:0] step,
                                               input logic [7:0]    len);
      logic [8+SW-1:0] res;
      res = {cnt + 8'h01, step};
      if (cnt >= len - 8'h01) begin
         res = {8'h00, SW'(step + 1'b1)}; // [RL1]
      end
      return res;
   endfunction

   // quarter-wave symmetric table, two's complement codes
   function automatic logic [7:0] sine_code(input logic [SW-1:0] idx);
      logic [3:0] h;
      logic [7:0] mag;
      h = idx[3:0];
      if (h > 4'h8) begin
         h = 4'h0 - h;
      end
      unique case (h)
         4'h0:    mag = 8'h00;
         4'h1:    mag = 8'h19;
         4'h2:    mag = 8'h31;
         4'h3:    mag = 8'h47;
         4'h4:    mag = 8'h5a;
         4'h5:    mag = 8'h6a;
         4'h6:    mag = 8'h75;
         4'h7:    mag = 8'h7d;
         default: mag = 8'h7f;
      endcase
      return idx[SW-1] ? (8'h00 - mag) : mag;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic        tx_wr;
      logic        ctrl_wr;
      logic        st_rd;
      logic        active;
      logic        present;
      logic        rx_set;
      logic        tx_set;
      logic        irq_set;
      logic [21:0] blen;
      logic [19:0] glast;
      tx_wr   = wr_i & (addr_i == dtg_pkg::ADDR_DATA);
      ctrl_wr = wr_i & (addr_i == dtg_pkg::ADDR_CTRL);
      st_rd   = rd_i & (addr_i == dtg_pkg::ADDR_CTRL);
      rx_set  = 1'b0;
      tx_set  = 1'b0;
      active  = 1'b0;
      present = 1'b0;
      irq_set = 1'b0;
      blen    = BURST_LEN;
      glast   = GTP_LAST;
      state_next = state_reg;

      // crystal tick: carry of a phase accumulator, never gated
      {state_next.tick, state_next.acc} =
         {1'b0, state_reg.acc} + dtg_pkg::CRYS_INC; // [RL5] [RL14]

      if (state_reg.tick) begin
         {state_next.row_div, state_next.row_step} =
            advance(state_reg.row_div, state_reg.row_step,
                    seg_len(state_reg.tx_sel[3:0], 1'b0)); // [RL3] [RL4] [RL7]
         {state_next.col_div, state_next.col_step} =
            advance(state_reg.col_div, state_reg.col_step,
                    seg_len(state_reg.tx_sel[7:4], 1'b1)); // [RL3] [RL4] [RL7]
      end

      // tone output gating
      active = state_reg.ctla[dtg_pkg::CTLA_TONE] &
               (~state_reg.ctlb[dtg_pkg::CTLB_BURST] |
                (state_reg.phase == dtg_pkg::BURST_ON)); // [RL20] [RL12]
      state_next.active  = active;
      state_next.row_smp = 8'h00;
      state_next.col_smp = 8'h00;
      if (active & ~(state_reg.ctlb[dtg_pkg::CTLB_SINGLE] &
                     state_reg.ctlb[dtg_pkg::CTLB_COLUMN])) begin
         state_next.row_smp = sine_code(state_reg.row_step); // [RL22] [RL13]
      end
      if (active & ~(state_reg.ctlb[dtg_pkg::CTLB_SINGLE] &
                     ~state_reg.ctlb[dtg_pkg::CTLB_COLUMN])) begin
         state_next.col_smp = sine_code(state_reg.col_step); // [RL22] [RL13]
      end

      // register writes
      if (tx_wr) begin
         state_next.tx_sel = two_of_eight(wr_data_i); // [RL2] [RL6]
      end
      if (ctrl_wr) begin
         if (state_reg.ctlb_pend) begin
            state_next.ctlb      = wr_data_i;
            state_next.ctlb_pend = 1'b0;
         end else begin
            state_next.ctla      = wr_data_i;
            state_next.ctlb_pend = wr_data_i[dtg_pkg::CTLA_BSEL];
         end
      end

      // burst and pause timer
      blen = state_reg.ctla[dtg_pkg::CTLA_CPSEL] ? {BURST_LEN[20:0], 1'b0}
                                                 : BURST_LEN; // [RL8] [RL10]
      unique case (state_reg.phase)
         dtg_pkg::BURST_IDLE: begin
            state_next.bcnt = 22'h000000;
         end
         dtg_pkg::BURST_ON: begin
            state_next.bcnt = state_reg.bcnt + 22'h000001;
            if (state_reg.bcnt >= blen - 22'h000001) begin
               state_next.phase = dtg_pkg::BURST_PAUSE; // [RL8]
               state_next.bcnt  = 22'h000000;
            end
         end
         dtg_pkg::BURST_PAUSE: begin
            state_next.bcnt = state_reg.bcnt + 22'h000001;
            if (state_reg.bcnt >= blen - 22'h000001) begin
               state_next.phase = dtg_pkg::BURST_IDLE;
               tx_set = 1'b1; // [RL9]
            end
         end
         default: state_next.phase = dtg_pkg::BURST_IDLE;
      endcase
      if (tx_wr & state_reg.ctlb[dtg_pkg::CTLB_BURST]) begin
         state_next.phase = dtg_pkg::BURST_ON;
         state_next.bcnt  = 22'h000000;
      end
      if (~state_reg.ctlb[dtg_pkg::CTLB_BURST]) begin
         state_next.phase = dtg_pkg::BURST_IDLE;
      end
      // a finishing pause beats a same-cycle write clear
      state_next.tx_ready = tx_set | (state_reg.tx_ready & ~tx_wr); // [RL9]

      // receiver input synchronisers
      state_next.es_s1   = early_steering_i;
      state_next.es_s2   = state_reg.es_s1;
      state_next.es_s3   = state_reg.es_s2;
      state_next.code_s1 = rx_digit_code_i;
      state_next.code_s2 = state_reg.code_s1;
      state_next.code_s3 = state_reg.code_s2;
      if (state_reg.es_s2 == state_reg.es_s3) begin
         state_next.es_lvl = state_reg.es_s3;
      end
      if (state_reg.code_s2 == state_reg.code_s3) begin
         state_next.code_lvl = state_reg.code_s3;
      end

      // steering: a change must persist for the guard time
      present = state_reg.es_lvl &
                ~state_reg.ctla[dtg_pkg::CTLA_CPSEL]; // [RL11] [RL21]
      glast   = state_reg.dsteer ? GTA_LAST : GTP_LAST;
      state_next.gcnt = 20'h00000;
      if (present != state_reg.dsteer) begin
         state_next.gcnt = state_reg.gcnt + 20'h00001; // [RL15] [RL16]
         if (state_reg.gcnt >= glast) begin
            state_next.dsteer = present;
            state_next.gcnt   = 20'h00000;
            if (present) begin
               state_next.rx_code = state_reg.code_lvl; // [RL16]
               rx_set = 1'b1;
            end
         end
      end

      // receive flag and interrupt; a new event wins over the read clear
      state_next.rx_valid = rx_set | (state_reg.rx_valid & ~st_rd); // [RL18]
      irq_set = state_reg.ctla[dtg_pkg::CTLA_IRQ] &
                ~state_reg.ctla[dtg_pkg::CTLA_CPSEL] &
                (rx_set | (tx_set & state_reg.ctlb[dtg_pkg::CTLB_BURST]));
      state_next.irq = irq_set | (state_reg.irq & ~st_rd); // [RL19]

      // read data valid only in the cycle after the strobe
      state_next.rdata = 4'h0;
      if (rd_i) begin
         if (addr_i == dtg_pkg::ADDR_DATA) begin
            state_next.rdata = state_reg.rx_code;
         end else begin
            state_next.rdata[dtg_pkg::ST_IRQ]      = state_reg.irq;
            state_next.rdata[dtg_pkg::ST_TXRDY]    = state_reg.tx_ready;
            state_next.rdata[dtg_pkg::ST_RXVALID]  = state_reg.rx_valid;
            state_next.rdata[dtg_pkg::ST_DSTEER_N] = ~state_reg.dsteer; // [RL17]
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg          <= '0;
         state_reg.tx_sel   <= 8'h88;
         state_reg.rx_code  <= dtg_pkg::CODE_RST;
         state_reg.ctla     <= dtg_pkg::CTLA_RST;
         state_reg.ctlb     <= dtg_pkg::CTLB_RST;
         state_reg.phase    <= dtg_pkg::BURST_IDLE;
         state_reg.tx_ready <= dtg_pkg::TXRDY_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign rd_data_o                  = state_reg.rdata;
   assign steering_guard_o           = state_reg.dsteer;
   assign interrupt_or_tone_pin_o    = 1'b0;
   assign interrupt_or_tone_pin_oe_o = state_reg.irq;
   assign row_sample_o               = state_reg.row_smp;
   assign col_sample_o               = state_reg.col_smp;
   assign tone_active_o              = state_reg.active;

endmodule

`default_nettype wire

//--- tb/dtg_detector_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtg_detector_model (
   // clock
   input  wire logic       clk_i,
   // scenario commands
   input  wire logic       tone_i,
   input  wire logic [3:0] digit_i,
   // detector outputs
   output logic            early_steering_o,
   output logic      [3:0] rx_digit_code_o
);
   logic       tone_reg  = 1'b0;
   logic [3:0] digit_reg = 4'h0;
   logic [3:0] churn_reg = 4'h0;
   always_ff @(posedge clk_i) begin
      tone_reg  <= tone_i;
      digit_reg <= digit_i;
      churn_reg <= churn_reg + 4'h5;
   end
   // no digit between tones: keep the code lines moving, never stale
   assign early_steering_o = tone_reg;
   assign rx_digit_code_o  = tone_reg ? digit_reg : churn_reg;
endmodule
`default_nettype wire

//--- tb/dtg_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtg_top_properties #(
   parameter int BURST_CYCLES = 200,
   parameter int GTP_CYCLES   = 20,
   parameter int GTA_CYCLES   = 20
) (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       addr_i,
   input wire logic [3:0] wr_data_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [3:0] rd_data_o,
   input wire logic       early_steering_i,
   input wire logic [3:0] rx_digit_code_i,
   input wire logic       steering_guard_o,
   input wire logic       interrupt_or_tone_pin_o,
   input wire logic       interrupt_or_tone_pin_oe_o,
   input wire logic [7:0] row_sample_o,
   input wire logic [7:0] col_sample_o,
   input wire logic       tone_active_o
);
   logic [3:0] ctla_q;
   logic [3:0] ctlb_q;
   logic       ctlb_sel;
   logic [7:0] prev_row;
   int         run;
   int         hi_run;
   int         lo_run;
   int         still;
   // shadow of the control pair so properties know the mode
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctla_q   <= 4'h0;
         ctlb_q   <= 4'h0;
         ctlb_sel <= 1'b0;
         prev_row <= 8'h00;
         run      <= 0;
         hi_run   <= 0;
         lo_run   <= 0;
         still    <= 0;
      end else begin
         if (wr_i && addr_i) begin
            if (ctlb_sel) ctlb_q <= wr_data_i;
            else ctla_q <= wr_data_i;
            ctlb_sel <= ctlb_sel ? 1'b0 : wr_data_i[3];
         end
         prev_row <= row_sample_o;
         run      <= tone_active_o ? run + 1 : 0;
         hi_run   <= early_steering_i ? hi_run + 1 : 0;
         lo_run   <= early_steering_i ? 0 : lo_run + 1;
         still    <= (tone_active_o && row_sample_o != 8'h00
                      && row_sample_o == prev_row) ? still + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_burst_length: assert property (
      $fell(tone_active_o) && ctlb_q[0] && ctla_q[0]
      |-> run == (ctla_q[1] ? 2 * BURST_CYCLES : BURST_CYCLES))
      else $error("burst length wrong");
   // a code change mid-segment never stretches a step past the sum of the old and new segment lengths
   a_segment_steps: assert property (still < 2300)
      else $error("row sample stuck");
   a_silent_zero: assert property (
      !tone_active_o [*2] |-> row_sample_o == 8'h00 && col_sample_o == 8'h00)
      else $error("samples not silent");
   a_tone_prompt: assert property (
      wr_i && addr_i && !ctlb_sel && wr_data_i[0] && !ctlb_q[0]
      |-> ##[1:2] tone_active_o)
      else $error("tone did not start");
   a_status_steer: assert property (
      rd_i && addr_i |=> rd_data_o[3] == !$past(steering_guard_o))
      else $error("status bit 3 wrong");
   a_guard_present: assert property (
      $rose(steering_guard_o) |-> $past(hi_run, 6) >= GTP_CYCLES - 8)
      else $error("tone accepted too early");
   a_guard_absent: assert property (
      $fell(steering_guard_o) |-> $past(lo_run, 6) >= GTA_CYCLES - 8)
      else $error("pause accepted too early");
   a_cp_blocks: assert property (
      ctla_q[1] && !steering_guard_o |=> !steering_guard_o)
      else $error("detection in call progress");
   a_irq_on_data: assert property (
      $rose(steering_guard_o) && ctla_q[2] && !ctla_q[1]
      |-> ##[0:2] interrupt_or_tone_pin_oe_o)
      else $error("interrupt missing");
   a_irq_release: assert property (
      rd_i && addr_i
      |=> !interrupt_or_tone_pin_oe_o || $changed(steering_guard_o))
      else $error("interrupt not released");
endmodule
`default_nettype wire

//--- tb/dtg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("BAD t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module dtg_top_tb;
   localparam int          BC  = 200;
   localparam int          GT  = 20;
   // per code: low group index in the upper pair, high in the lower
   localparam logic [63:0] SEL = 64'hb73e_cda9_8654_210f;
   real        lo_hz [4] = '{699.1, 766.2, 847.4, 948.0};
   real        hi_hz [4] = '{1215.9, 1331.7, 1471.9, 1645.0};
   logic       clk_i     = 1'b0;
   logic       resetn_i  = 1'b0;
   logic       addr_i    = 1'b0;
   logic [3:0] wr_data_i = 4'h0;
   logic       wr_i      = 1'b0;
   logic       rd_i      = 1'b0;
   logic       tone      = 1'b0;
   logic [3:0] digit     = 4'h0;
   logic [3:0] rd_data_o;
   logic       early_steering_i;
   logic [3:0] rx_digit_code_i;
   logic       steering_guard_o;
   logic       interrupt_or_tone_pin_o;
   logic       interrupt_or_tone_pin_oe_o;
   logic [7:0] row_sample_o;
   logic [7:0] col_sample_o;
   logic       tone_active_o;
   int         errors      = 0;
   int         comparisons = 0;

   always #20 clk_i = ~clk_i;

   dtg_top #(.BURST_CYCLES(BC), .GTP_CYCLES(GT), .GTA_CYCLES(GT)) dut (.*);
   dtg_detector_model u_det (
      .clk_i            (clk_i),
      .tone_i           (tone),
      .digit_i          (digit),
      .early_steering_o (early_steering_i),
      .rx_digit_code_o  (rx_digit_code_i)
   );

   // ---------------------------------------------------------------
   // bus and timing helpers
   // ---------------------------------------------------------------
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic a, input logic [3:0] d);
      @(posedge clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic a, input logic [3:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      `CHK(rd_data_o, e)
   endtask
   task automatic hold(input logic on, input logic [3:0] d, input int n);
      tone  <= on;
      digit <= d;
      repeat (n) tick;
   endtask
   task automatic seg(input logic col, input real hz);
      logic [7:0] v;
      int         n;
      real        d;
      // first two steps may be partial or still on the old code
      for (int k = 0; k < 3; k++) begin
         v = col ? col_sample_o : row_sample_o;
         n = 0;
         while ((col ? col_sample_o : row_sample_o) === v && n < 2500) begin
            tick;
            n++;
         end
      end
      d = real'(n) - real'(dtg_pkg::CLK_HZ) / (32.0 * hz);
      `CHK(d * d < 9.0, 1'b1)
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_rx;
      wr(1'b1, 4'h4);
      hold(1'b1, 4'h5, GT + 10);
      `CHK(steering_guard_o, 1'b1)
      `CHK(interrupt_or_tone_pin_oe_o, 1'b1)
      `CHK(interrupt_or_tone_pin_o, 1'b0)
      rd(1'b1, 4'h7);
      rd(1'b1, 4'h2);
      rd(1'b0, 4'h5);
      hold(1'b0, 4'h5, GT - 8);
      hold(1'b1, 4'h5, GT + 10);
      rd(1'b1, 4'h2);
      hold(1'b0, 4'h0, GT + 10);
      rd(1'b1, 4'ha);
      hold(1'b1, 4'h9, GT - 8);
      hold(1'b0, 4'h0, GT + 10);
      rd(1'b1, 4'ha);
      rd(1'b0, 4'h5);
   endtask
   task automatic t_burst(input logic cp);
      int n;
      // burst on before tone on, so no free-running tone precedes the burst
      wr(1'b1, {2'b11, cp, 1'b0});
      wr(1'b1, 4'h1);
      wr(1'b1, {2'b01, cp, 1'b1});
      hold(cp, 4'h9, 1);
      wr(1'b0, 4'h9);
      n = 0;
      while (tone_active_o !== 1'b1 && n < 8) begin
         tick;
         n++;
      end
      n = 0;
      while (tone_active_o === 1'b1 && n < 1000) begin
         tick;
         n++;
      end
      `CHK(n, cp ? 2 * BC : BC)
      repeat (n - 10) tick;
      rd(1'b1, 4'h8);
      repeat (20) tick;
      rd(1'b1, cp ? 4'ha : 4'hb);
      hold(1'b0, 4'h0, 1);
      wr(1'b1, 4'h8);
      wr(1'b1, 4'h0);
   endtask
   task automatic t_gate;
      wr(1'b1, 4'h1);
      tick;
      `CHK(tone_active_o, 1'b1)
      wr(1'b1, 4'h0);
      repeat (2) tick;
      `CHK({tone_active_o, row_sample_o, col_sample_o}, 17'h0)
      wr(1'b1, 4'h9);
      wr(1'b1, 4'h4);
      repeat (1200) tick;
      `CHK(col_sample_o, 8'h00)
      wr(1'b1, 4'h9);
      wr(1'b1, 4'hc);
      repeat (1200) tick;
      `CHK(row_sample_o, 8'h00)
      wr(1'b1, 4'h9);
      wr(1'b1, 4'h0);
   endtask
   task automatic t_tone;
      for (int k = 0; k < 16; k++) begin
         wr(1'b0, 4'(k));
         fork
            seg(1'b0, lo_hz[SEL[4*k+2 +: 2]]);
            seg(1'b1, hi_hz[SEL[4*k +: 2]]);
         join
      end
   endtask

   task automatic conclude;
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (100_000) @(posedge clk_i);
      errors++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(1'b1, 4'ha);
      rd(1'b0, 4'h0);
      $display("idle test done");
      t_rx;
      $display("receive test done");
      t_burst(1'b0);
      t_burst(1'b1);
      $display("burst test done");
      t_gate;
      $display("gate test done");
      t_tone;
      $display("tone test done");
      conclude;
   end
endmodule
bind dtg_top dtg_top_properties #(
   .BURST_CYCLES (BURST_CYCLES),
   .GTP_CYCLES   (GTP_CYCLES),
   .GTA_CYCLES   (GTA_CYCLES)
) u_props (.*);
`default_nettype wire
